// ---- verilog/scs_pkg.sv ----
// Constants for the sample clock trim and sync select block
package scs_pkg;

    // ****************************************************
    // Register indices (byte address is four times these)
    // ****************************************************
    localparam logic [8:0]  SLOW_TRIM_IDX   = 9'h04b;
    localparam logic [8:0]  FAST_TRIM_IDX   = 9'h04d;
    localparam logic [8:0]  PIN_SYNC_IDX    = 9'h04f;
    localparam int          ADDR_W          = 11;
    localparam int          IDX_LSB         = 2;

    // ****************************************************
    // Reset values
    // ****************************************************
    localparam logic [15:0] SLOW_TRIM_RST   = 16'h2612;
    localparam logic [15:0] FAST_TRIM_RST   = 16'h0098;
    localparam logic [15:0] PIN_SYNC_RST    = 16'h2090;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int          SLOW_TRIM_LSB   = 0;
    localparam int          SLOW_TRIM_W     = 6;
    localparam int          SLOW_EN_BIT     = 7;
    localparam int          SLOW_BYP_BIT    = 8;
    localparam int          FAST_TRIM_LSB   = 0;
    localparam int          FAST_TRIM_W     = 8;
    localparam int          PIN1_OE_BIT     = 6;
    localparam int          PIN1_IE_BIT     = 5;
    localparam int          SYNC_SEL_LSB    = 2;
    localparam int          PIN0_IE_BIT     = 1;

    // ****************************************************
    // Sample timing
    // ****************************************************
    localparam int          DIV_W           = 16;
    localparam int          TICKS_PER_UNIT  = 4;
    localparam int          CNT_W           = 18;

    typedef enum logic [1:0] {
        SCS_SYNC_INTERNAL,
        SCS_SYNC_PIN0,
        SCS_SYNC_PIN1,
        SCS_SYNC_RESERVED
    } scs_sync_t;

endpackage : scs_pkg

// ---- verilog/scs_clock_sync_ctrl.sv ----
// Clock trim registers, aux pin control and sample sync selection
module scs_clock_sync_ctrl
    import scs_pkg::*;
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // Avalon-MM slave
    input  wire logic [scs_pkg::ADDR_W-1:0]    address,
    input  wire logic                          read,
    input  wire logic                          write,
    input  wire logic [31:0]                   writedata,
    input  wire logic [3:0]                    byteenable,
    output logic      [31:0]                   readdata,
    output logic                               waitrequest,
    // Oscillator control
    input  wire logic                          slow_osc_clk,
    output logic      [scs_pkg::SLOW_TRIM_W-1:0] slow_clock_trim,
    output logic                               slow_osc_enable,
    output logic                               slow_osc_bypass,
    output logic      [scs_pkg::FAST_TRIM_W-1:0] fast_clock_trim,
    // Sample timing
    input  wire logic [scs_pkg::DIV_W-1:0]     sample_period_divider,
    output logic                               sample_start,
    // Aux pins
    input  wire logic                          aux_pin_zero_in,
    input  wire logic                          aux_pin_one_in,
    output logic                               aux_pin_one_out,
    output logic                               aux_pin1_output_enable
);

    import scs_pkg::*;

    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        logic [15:0]      slow_cfg;
        logic [15:0]      fast_cfg;
        logic [15:0]      pin_cfg;
        logic             wait_req;
        logic [15:0]      rdata;
        logic [2:0]       meta;
        logic [2:0]       sync;
        logic [2:0]       prev;
        logic [CNT_W-1:0] tick_cnt;
        logic             sample_start;
    } scs_state_t;

    scs_state_t st;
    scs_state_t next_st;

    // ****************************************************
    // Byte lane merge
    // ****************************************************
    function automatic logic [15:0] scs_merge(
        input logic [15:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0]  be
    );
        logic [15:0] res;
        res = old_val;
        if (be[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction : scs_merge

    // ****************************************************
    // Next state
    // ****************************************************
    logic [8:0]       idx;
    logic             wr_now;
    logic [2:0]       edge_seen;
    logic             pin0_trig;
    logic             pin1_trig;
    logic             slow_tick;
    logic [CNT_W-1:0] period_ticks;
    logic [CNT_W-1:0] cnt_inc;
    scs_sync_t        sync_sel;

    always_comb begin
        next_st = st;
        idx     = address[IDX_LSB +: 9];
        wr_now  = write && !st.wait_req;

        // Bus: one wait cycle, then a single acknowledge cycle
        if ((read || write) && st.wait_req) begin
            next_st.wait_req = 1'b0;
            case (idx)
                SLOW_TRIM_IDX: next_st.rdata = st.slow_cfg;
                FAST_TRIM_IDX: next_st.rdata = st.fast_cfg;
                PIN_SYNC_IDX:  next_st.rdata = st.pin_cfg;
                default:       next_st.rdata = 16'h0000;
            endcase
        end else begin
            next_st.wait_req = 1'b1;
        end

        // Only the addressed register changes; unmapped writes drop
        if (wr_now) begin
            case (idx)
                SLOW_TRIM_IDX: next_st.slow_cfg =
                    scs_merge(st.slow_cfg, writedata, byteenable);
                FAST_TRIM_IDX: next_st.fast_cfg =
                    scs_merge(st.fast_cfg, writedata, byteenable);
                PIN_SYNC_IDX:  next_st.pin_cfg =
                    scs_merge(st.pin_cfg, writedata, byteenable);
                default: ;
            endcase
        end

        // Pins and oscillator pass two flops before any use
        next_st.meta = {slow_osc_clk, aux_pin_one_in, aux_pin_zero_in};
        next_st.sync = st.meta;
        next_st.prev = st.sync;
        edge_seen    = st.sync & ~st.prev;

        pin0_trig = edge_seen[0] && st.pin_cfg[PIN0_IE_BIT];
        pin1_trig = edge_seen[1] && st.pin_cfg[PIN1_IE_BIT];

        // Bypass takes the slow clock from aux pin one
        slow_tick = st.slow_cfg[SLOW_BYP_BIT] ? pin1_trig
                                              : edge_seen[2];
        slow_tick = slow_tick && st.slow_cfg[SLOW_EN_BIT];

        // Period is divider times four slow clock cycles
        period_ticks = {sample_period_divider, 2'b00};
        cnt_inc      = st.tick_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        sync_sel     = scs_sync_t'(st.pin_cfg[SYNC_SEL_LSB +: 2]);

        next_st.sample_start = 1'b0;
        case (sync_sel)
            SCS_SYNC_INTERNAL: begin
                // Divider of zero stops sampling rather than free running
                if (period_ticks == '0) begin
                    next_st.tick_cnt = '0;
                end else if (slow_tick) begin
                    if (cnt_inc >= period_ticks) begin
                        next_st.tick_cnt     = '0;
                        next_st.sample_start = 1'b1;
                    end else begin
                        next_st.tick_cnt = cnt_inc;
                    end
                end
            end
            SCS_SYNC_PIN0: begin
                next_st.tick_cnt     = '0;
                next_st.sample_start = pin0_trig;
            end
            SCS_SYNC_PIN1: begin
                next_st.tick_cnt     = '0;
                next_st.sample_start = pin1_trig;
            end
            default: begin
                // Reserved source: no samples start
                next_st.tick_cnt = '0;
            end
        endcase
    end

    // ****************************************************
    // Registers
    // ****************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st              <= '0;
            st.slow_cfg     <= SLOW_TRIM_RST;
            st.fast_cfg     <= FAST_TRIM_RST;
            st.pin_cfg      <= PIN_SYNC_RST;
            st.wait_req     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign readdata    = {16'h0000, st.rdata};
    assign waitrequest = st.wait_req;

    // Raw code to the oscillator; inverse slope lives in the analog cell
    assign slow_clock_trim =
        st.slow_cfg[SLOW_TRIM_LSB +: SLOW_TRIM_W];
    assign slow_osc_enable = st.slow_cfg[SLOW_EN_BIT];
    assign slow_osc_bypass = st.slow_cfg[SLOW_BYP_BIT];

    // Direct slope; this oscillator times the LED pulses
    assign fast_clock_trim =
        st.fast_cfg[FAST_TRIM_LSB +: FAST_TRIM_W];

    assign sample_start = st.sample_start;

    // Pin level selection lives elsewhere; the driver here pulls low
    assign aux_pin_one_out        = st.rdata[0] & 1'b0;
    assign aux_pin1_output_enable = st.pin_cfg[PIN1_OE_BIT];

endmodule : scs_clock_sync_ctrl

// ---- verification/scs_ctrl_props.sv ----
// Bus and output checker for the clock sync control block
module scs_ctrl_props
    import scs_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Bus
    input wire logic [10:0] address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Outputs
    input wire logic [5:0]  slow_clock_trim,
    input wire logic [7:0]  fast_clock_trim,
    input wire logic        sample_start,
    input wire logic        aux_pin1_output_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_wr(idx);
        write && !waitrequest && byteenable[0] && address[10:2] == idx;
    endsequence
    a_bus_answer: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("no bus answer");
    a_bus_release: assert property (!waitrequest |=> waitrequest)
        else $error("answer too long");
    a_slow_write: assert property (s_wr(SLOW_TRIM_IDX) |=>
        slow_clock_trim == $past(writedata[5:0])) else $error("slow trim");
    a_fast_write: assert property (s_wr(FAST_TRIM_IDX) |=>
        fast_clock_trim == $past(writedata[7:0])) else $error("fast trim");
    a_pin_oe: assert property (s_wr(PIN_SYNC_IDX) |=>
        aux_pin1_output_enable == $past(writedata[6])) else $error("oe");
    a_cfg_hold: assert property (!(write && !waitrequest) |=> $stable(
        {slow_clock_trim, fast_clock_trim, aux_pin1_output_enable}))
        else $error("config moved");
    a_fast_read: assert property (read && !waitrequest &&
        address[10:2] == FAST_TRIM_IDX |-> readdata[7:0] == fast_clock_trim)
        else $error("fast readback");
    a_start_pulse: assert property (sample_start |=> !sample_start)
        else $error("start too long");
endmodule : scs_ctrl_props
bind scs_clock_sync_ctrl scs_ctrl_props u_props (.clk, .rstn, .address,
    .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .slow_clock_trim, .fast_clock_trim, .sample_start,
    .aux_pin1_output_enable);

// ---- verification/scs_trig_src.sv ----
// External trigger source and slow clock on the aux pins
module scs_trig_src (
    // Bench side
    input  wire logic clk,
    input  wire logic slow_run,
    input  wire logic bypass,
    input  wire logic pin1_oe,
    input  wire logic pin1_out,
    // Pins
    output logic      slow_osc_clk,
    output logic      aux_pin_zero_in,
    output logic      aux_pin_one_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       pin1_lvl = 1'b0;
    logic [3:0] tick     = 4'h0;
    initial slow_osc_clk = 1'b0;
    initial aux_pin_zero_in = 1'b0;
    // Stands still when stopped, so no stray ticks
    always @(posedge clk) begin
        if (slow_run) begin
            tick <= (tick == 4'h9) ? 4'h0 : tick + 4'h1;
            slow_osc_clk <= slow_osc_clk ^ (tick == 4'h9);
        end
    end
    // Device driver wins; bypass puts the clock on pin one
    assign aux_pin_one_in = pin1_oe ? pin1_out :
        (bypass ? slow_osc_clk : pin1_lvl);
    // Low gap after each trigger so edges stay distinct
    task automatic pulse(input logic pin);
        @(posedge clk);
        pin1_lvl <= pin;
        aux_pin_zero_in <= !pin;
        repeat (3) @(posedge clk);
        pin1_lvl <= 1'b0;
        aux_pin_zero_in <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse
endmodule : scs_trig_src

// ---- verification/test_scs_clock_sync_ctrl.sv ----
// Self-checking bench for the clock sync control block
module test_scs_clock_sync_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import scs_pkg::*;
    logic        clk, rstn, read, write, slow_run, bypass;
    logic        waitrequest, start, oe, pin_out, sclk, pin0, pin1, sen;
    logic [10:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0]  byteenable;
    logic [15:0] divider, q;
    logic [5:0]  slow_trim;
    logic [7:0]  fast_trim;
    int          bad_count = 0, samples_checked = 0, cycles = 0, starts = 0;
    scs_clock_sync_ctrl u_scs_clock_sync_ctrl (.clk, .rstn, .address, .read,
        .write, .writedata, .byteenable, .readdata, .waitrequest,
        .slow_osc_clk(sclk), .slow_clock_trim(slow_trim),
        .slow_osc_enable(sen),
        .slow_osc_bypass(bypass), .fast_clock_trim(fast_trim),
        .sample_period_divider(divider), .sample_start(start),
        .aux_pin_zero_in(pin0), .aux_pin_one_in(pin1),
        .aux_pin_one_out(pin_out), .aux_pin1_output_enable(oe));
    scs_trig_src u_scs_trig_src (.clk, .slow_run, .bypass, .pin1_oe(oe),
        .pin1_out(pin_out), .slow_osc_clk(sclk), .aux_pin_zero_in(pin0),
        .aux_pin_one_in(pin1));
    initial begin
        clk = 1'b0;
        forever #2 clk = !clk;
    end
    // Whole run needs about eight hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        starts <= starts + int'(start === 1'b1);
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(logic w, logic [8:0] idx, logic [15:0] d);
        address <= {idx, 2'b00};
        read <= !w;
        write <= w;
        writedata <= {16'h0000, d};
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata[15:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic t_regs();
        logic [8:0]  idx [4] = '{SLOW_TRIM_IDX, FAST_TRIM_IDX, PIN_SYNC_IDX,
                                 9'h04c};
        logic [15:0] rst [4] = '{16'h2612, 16'h0098, 16'h2090, 16'h0000};
        foreach (idx[i]) begin
            bus(1'b0, idx[i], 16'h0000);
            check("reset value", q, rst[i]);
        end
        $display("t_regs done");
    endtask : t_regs
    task automatic t_trims();
        logic [7:0] codes [3] = '{8'h00, 8'h22, 8'hff};
        foreach (codes[i]) begin
            bus(1'b1, SLOW_TRIM_IDX, {10'h098, codes[i][5:0]});
            check("slow trim", {10'h000, slow_trim}, codes[i][5:0]);
            bus(1'b1, FAST_TRIM_IDX, {8'h00, codes[i]});
            check("fast trim", {8'h00, fast_trim}, codes[i]);
            bus(1'b0, SLOW_TRIM_IDX, 16'h0000);
            check("slow read", q, {10'h098, codes[i][5:0]});
        end
        $display("t_trims done");
    endtask : t_trims
    task automatic t_sync();
        logic [15:0] cfg [5] = '{16'h20f2, 16'h20b6, 16'h20ba, 16'h20be,
                                 16'h2098};
        logic [1:0]  exp [5] = '{2'b00, 2'b01, 2'b10, 2'b00, 2'b00};
        int          base;
        foreach (cfg[i]) begin
            bus(1'b1, PIN_SYNC_IDX, cfg[i]);
            check("pin oe", {15'h0000, oe}, {15'h0000, cfg[i][6]});
            check("pin out", {15'h0000, pin_out}, 16'h0000);
            for (int p = 0; p < 2; p++) begin
                base = starts;
                u_scs_trig_src.pulse(p[0]);
                repeat (4) @(posedge clk);
                check("pin starts", 16'(starts - base), {15'h0000, exp[i][p]});
            end
        end
        $display("t_sync done");
    endtask : t_sync
    task automatic t_internal();
        int base;
        bus(1'b1, PIN_SYNC_IDX, 16'h20b0);
        divider <= 16'h0001;
        slow_run <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            bus(1'b1, SLOW_TRIM_IDX, 16'h2692 | 16'(b << 8));
            check("slow enable", {15'h0000, sen}, 16'h0001);
            base = starts;
            repeat (300) @(posedge clk);
            check("timed starts", {15'h0000, (starts - base) > 0}, 16'h0001);
        end
        slow_run <= 1'b0;
        $display("t_internal done");
    endtask : t_internal
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    initial begin
        rstn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        slow_run = 1'b0;
        address = 11'h000;
        writedata = 32'h0000_0000;
        byteenable = 4'h3;
        divider = 16'h0000;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_trims();
        t_sync();
        t_internal();
        end_of_test();
    end
endmodule : test_scs_clock_sync_ctrl
